// ==== shared/sesp_consts.svh ====
// named constants of the serial eeprom status and protection block
`ifndef SESP_CONSTS_SVH
`define SESP_CONSTS_SVH

// ************************************************************
// opcodes, sent msb first as the first byte of a frame
// ************************************************************
`define SESP_OP_ENABLE_WRITE 8'h06
`define SESP_OP_DISABLE_WRITE 8'h04
`define SESP_OP_STATUS_READ 8'h05
`define SESP_OP_STATUS_WRITE 8'h01
`define SESP_OP_ARRAY_READ 8'h03
`define SESP_OP_ARRAY_WRITE 8'h02

// ************************************************************
// block protect encodings and area boundaries
// ************************************************************
`define SESP_BP_NONE 2'h0
`define SESP_BP_QUARTER 2'h1
`define SESP_BP_HALF 2'h2
`define SESP_QUARTER_BASE 16'hc000
`define SESP_HALF_BASE 16'h8000

// ************************************************************
// frame counts
// ************************************************************
`define SESP_LAST_BIT 3'h7
`define SESP_FIRST_BIT 3'h0
`define SESP_LAST_ADDR_BIT 4'hf
`define SESP_ADDR_W 16

// ************************************************************
// reset values
// ************************************************************
// pin order sck, cs_n, mosi, wp_n; cs_n starts low so that a high level must be seen first
`define SESP_PINS_RESET 4'h1
`define SESP_DISABLE_RESET 1'h0
`define SESP_BP_RESET 2'h0

// ************************************************************
// timing
// ************************************************************
`define SESP_CLK_KHZ 10000
// self-timed cycle length, plain default
`define SESP_WRITE_TIME_US 1000
`define SESP_WRITE_CYCLES ((`SESP_WRITE_TIME_US * `SESP_CLK_KHZ) / 1000)

`endif

// ==== shared/sesp_pkg.sv ====
// types of the serial eeprom status and protection block
package sesp_pkg;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
    logic wp_n;
  } sesp_pins_t;

  typedef struct packed {
    logic status_write_disable;
    logic [2:0] zero;
    logic block_protect_hi;
    logic block_protect_lo;
    logic write_enable_latch;
    logic write_in_progress_flag;
  } sesp_status_t;

  // ************************************************************
  // frame states
  // ************************************************************
  typedef enum logic [3:0] {
    SESP_IDLE,
    SESP_OPCODE,
    SESP_WAIT_CMD,
    SESP_STATUS_OUT,
    SESP_STATUS_DATA,
    SESP_STATUS_DONE,
    SESP_ADDR,
    SESP_WRITE_DATA,
    SESP_IGNORE
  } sesp_state_t;

endpackage

// ==== hw/sesp_write_timer.sv ====
// self-timed write cycle counter
`timescale 1ns/10ps
`include "sesp_consts.svh"

module sesp_write_timer #(
  parameter int unsigned CYCLES = `SESP_WRITE_CYCLES,
  parameter int unsigned W = $clog2(CYCLES + 1)
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  output logic busy,
  output logic done
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // ************************************************************
  // counter
  // ************************************************************
  // a start while running is dropped: the caller only starts when idle
  always_comb begin
    cnt_next = cnt_reg;
    if (start && (cnt_reg == '0)) begin
      cnt_next = W'(CYCLES);
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - W'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign busy = (cnt_reg != '0);
  // last busy cycle; results are committed on the same edge that ends busy
  assign done = (cnt_reg == W'(1));

endmodule

// ==== hw/sesp_top.sv ====
// instruction decode, status byte and write protection of a serial eeprom
`timescale 1ns/10ps
`include "sesp_consts.svh"

module sesp_top
  import sesp_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `SESP_WRITE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wp_n,
  output logic miso_out,
  output logic miso_oe,
  output logic array_wr_start,
  output logic [`SESP_ADDR_W-1:0] array_wr_addr,
  output logic write_in_progress_flag,
  output logic write_enable_latch,
  output logic status_write_disable,
  output logic [1:0] block_protect,
  output logic software_protected_mode,
  output logic hardware_protected_mode,
  output logic [7:0] status_protect_byte
);

  // ************************************************************
  // pin synchronisers and edge detection
  // ************************************************************
  sesp_pins_t sync1_reg;
  sesp_pins_t sync1_next;
  sesp_pins_t sync2_reg;
  sesp_pins_t sync2_next;
  sesp_pins_t prev_reg;
  sesp_pins_t prev_next;
  logic armed_reg;
  logic armed_next;

  always_comb begin
    sync1_next = '{sck: sck, cs_n: cs_n, mosi: mosi, wp_n: wp_n};
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
    // no frame may start until select has been seen high after reset
    armed_next = armed_reg | sync2_reg.cs_n;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= `SESP_PINS_RESET;
      sync2_reg <= `SESP_PINS_RESET;
      prev_reg <= `SESP_PINS_RESET;
      armed_reg <= 1'h0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
      armed_reg <= armed_next;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;

  // the link clock is eight reference clocks long, so edges are found by sampling
  assign sck_rise = sync2_reg.sck & ~prev_reg.sck;
  assign sck_fall = ~sync2_reg.sck & prev_reg.sck;
  assign cs_rise = sync2_reg.cs_n & ~prev_reg.cs_n;
  assign cs_fall = ~sync2_reg.cs_n & prev_reg.cs_n;

  // ************************************************************
  // self-timed cycle
  // ************************************************************
  logic timer_start;
  logic timer_busy;
  logic timer_done;

  sesp_write_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(timer_start),
    .busy(timer_busy),
    .done(timer_done)
  );

  // ************************************************************
  // protection helpers
  // ************************************************************
  function automatic logic addr_protected(input logic [1:0] bp, input logic [`SESP_ADDR_W-1:0] a);
    logic hit;
    case (bp)
      `SESP_BP_NONE: hit = 1'h0;
      `SESP_BP_QUARTER: hit = (a >= `SESP_QUARTER_BASE);
      `SESP_BP_HALF: hit = (a >= `SESP_HALF_BASE);
      default: hit = 1'h1;
    endcase
    return hit;
  endfunction

  // ************************************************************
  // frame and status state
  // ************************************************************
  sesp_state_t state_reg;
  sesp_state_t state_next;
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] addr_cnt_reg;
  logic [3:0] addr_cnt_next;
  logic [`SESP_ADDR_W-1:0] addr_reg;
  logic [`SESP_ADDR_W-1:0] addr_next;
  logic data_seen_reg;
  logic data_seen_next;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;
  logic [7:0] out_sh_reg;
  logic [7:0] out_sh_next;
  logic [2:0] out_cnt_reg;
  logic [2:0] out_cnt_next;
  logic miso_reg;
  logic miso_next;
  logic oe_reg;
  logic oe_next;
  logic wr_disable_reg;
  logic wr_disable_next;
  logic [1:0] bp_reg;
  logic [1:0] bp_next;
  logic latch_reg;
  logic latch_next;
  logic pend_disable_reg;
  logic pend_disable_next;
  logic [1:0] pend_bp_reg;
  logic [1:0] pend_bp_next;
  logic cyc_status_reg;
  logic cyc_status_next;
  logic wr_start_reg;
  logic wr_start_next;
  logic [`SESP_ADDR_W-1:0] wr_addr_reg;
  logic [`SESP_ADDR_W-1:0] wr_addr_next;

  sesp_status_t status_now;
  logic hw_protect;

  always_comb begin
    status_now.status_write_disable = wr_disable_reg;
    status_now.zero = 3'h0;
    status_now.block_protect_hi = bp_reg[1];
    status_now.block_protect_lo = bp_reg[0];
    status_now.write_enable_latch = latch_reg;
    status_now.write_in_progress_flag = timer_busy;
  end

  assign hw_protect = wr_disable_reg & ~sync2_reg.wp_n;

  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    addr_cnt_next = addr_cnt_reg;
    addr_next = addr_reg;
    data_seen_next = data_seen_reg;
    cmd_next = cmd_reg;
    out_sh_next = out_sh_reg;
    out_cnt_next = out_cnt_reg;
    miso_next = miso_reg;
    oe_next = oe_reg;
    wr_disable_next = wr_disable_reg;
    bp_next = bp_reg;
    latch_next = latch_reg;
    pend_disable_next = pend_disable_reg;
    pend_bp_next = pend_bp_reg;
    cyc_status_next = cyc_status_reg;
    wr_start_next = 1'h0;
    wr_addr_next = wr_addr_reg;
    timer_start = 1'h0;
    if (sync2_reg.cs_n) begin
      // deselected: a pending instruction executes on the select rise only
      if (cs_rise) begin
        case (state_reg)
          SESP_WAIT_CMD: begin
            if (!timer_busy) begin
              if (cmd_reg == `SESP_OP_ENABLE_WRITE) begin
                latch_next = 1'h1;
              end else begin
                latch_next = 1'h0;
              end
            end
          end
          SESP_STATUS_DONE: begin
            // hardware mode and a clear latch both refuse; disable bit low ignores the pin
            if (latch_reg && !timer_busy && !hw_protect) begin
              pend_disable_next = shift_reg[7];
              pend_bp_next = shift_reg[3:2];
              cyc_status_next = 1'h1;
              timer_start = 1'h1;
            end
          end
          SESP_WRITE_DATA: begin
            // only at a byte boundary with at least one whole data byte
            if ((bit_cnt_reg == `SESP_FIRST_BIT) && data_seen_reg && latch_reg && !timer_busy &&
                !addr_protected(bp_reg, addr_reg)) begin
              wr_start_next = 1'h1;
              wr_addr_next = addr_reg;
              cyc_status_next = 1'h0;
              timer_start = 1'h1;
            end
          end
          default: begin
          end
        endcase
      end
      state_next = SESP_IDLE;
      oe_next = 1'h0;
    end else if (cs_fall) begin
      state_next = armed_reg ? SESP_OPCODE : SESP_IGNORE;
      bit_cnt_next = `SESP_FIRST_BIT;
    end else if (sck_rise) begin
      shift_next = {shift_reg[6:0], sync2_reg.mosi};
      bit_cnt_next = bit_cnt_reg + 3'h1;
      case (state_reg)
        SESP_OPCODE: begin
          if (bit_cnt_reg == `SESP_LAST_BIT) begin
            case (shift_next)
              `SESP_OP_ENABLE_WRITE, `SESP_OP_DISABLE_WRITE: begin
                cmd_next = shift_next;
                state_next = SESP_WAIT_CMD;
              end
              `SESP_OP_STATUS_READ: begin
                out_cnt_next = `SESP_FIRST_BIT;
                state_next = SESP_STATUS_OUT;
              end
              `SESP_OP_STATUS_WRITE: begin
                state_next = SESP_STATUS_DATA;
              end
              `SESP_OP_ARRAY_WRITE: begin
                addr_cnt_next = 4'h0;
                data_seen_next = 1'h0;
                state_next = SESP_ADDR;
              end
              // array read data path lives outside this block
              `SESP_OP_ARRAY_READ: state_next = SESP_IGNORE;
              default: state_next = SESP_IGNORE;
            endcase
          end
        end
        SESP_ADDR: begin
          addr_next = {addr_reg[`SESP_ADDR_W-2:0], sync2_reg.mosi};
          addr_cnt_next = addr_cnt_reg + 4'h1;
          if (addr_cnt_reg == `SESP_LAST_ADDR_BIT) begin
            bit_cnt_next = `SESP_FIRST_BIT;
            state_next = SESP_WRITE_DATA;
          end
        end
        SESP_WRITE_DATA: begin
          if (bit_cnt_reg == `SESP_LAST_BIT) begin
            data_seen_next = 1'h1;
          end
        end
        SESP_STATUS_DATA: begin
          if (bit_cnt_reg == `SESP_LAST_BIT) begin
            state_next = SESP_STATUS_DONE;
          end
        end
        // a ninth bit after a status byte, or any bit after enable/disable, voids the frame
        SESP_STATUS_DONE: state_next = SESP_IGNORE;
        SESP_WAIT_CMD: state_next = SESP_IGNORE;
        default: begin
        end
      endcase
    end else if (sck_fall && (state_reg == SESP_STATUS_OUT)) begin
      // the byte is refreshed every eight bits, so polling sees the busy flag drop
      oe_next = 1'h1;
      out_cnt_next = out_cnt_reg + 3'h1;
      if (out_cnt_reg == `SESP_FIRST_BIT) begin
        miso_next = status_now[7];
        out_sh_next = {status_now[6:0], 1'h0};
      end else begin
        miso_next = out_sh_reg[7];
        out_sh_next = {out_sh_reg[6:0], 1'h0};
      end
    end
    if (timer_done) begin
      if (cyc_status_reg) begin
        wr_disable_next = pend_disable_reg;
        bp_next = pend_bp_reg;
      end
      latch_next = 1'h0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= SESP_IDLE;
      bit_cnt_reg <= `SESP_FIRST_BIT;
      shift_reg <= 8'h00;
      addr_cnt_reg <= 4'h0;
      addr_reg <= '0;
      data_seen_reg <= 1'h0;
      cmd_reg <= 8'h00;
      out_sh_reg <= 8'h00;
      out_cnt_reg <= `SESP_FIRST_BIT;
      miso_reg <= 1'h0;
      oe_reg <= 1'h0;
      wr_disable_reg <= `SESP_DISABLE_RESET;
      bp_reg <= `SESP_BP_RESET;
      latch_reg <= 1'h0;
      pend_disable_reg <= `SESP_DISABLE_RESET;
      pend_bp_reg <= `SESP_BP_RESET;
      cyc_status_reg <= 1'h0;
      wr_start_reg <= 1'h0;
      wr_addr_reg <= '0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      addr_cnt_reg <= addr_cnt_next;
      addr_reg <= addr_next;
      data_seen_reg <= data_seen_next;
      cmd_reg <= cmd_next;
      out_sh_reg <= out_sh_next;
      out_cnt_reg <= out_cnt_next;
      miso_reg <= miso_next;
      oe_reg <= oe_next;
      wr_disable_reg <= wr_disable_next;
      bp_reg <= bp_next;
      latch_reg <= latch_next;
      pend_disable_reg <= pend_disable_next;
      pend_bp_reg <= pend_bp_next;
      cyc_status_reg <= cyc_status_next;
      wr_start_reg <= wr_start_next;
      wr_addr_reg <= wr_addr_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign miso_out = miso_reg;
  assign miso_oe = oe_reg;
  assign array_wr_start = wr_start_reg;
  assign array_wr_addr = wr_addr_reg;
  assign write_in_progress_flag = timer_busy;
  assign write_enable_latch = latch_reg;
  assign status_write_disable = wr_disable_reg;
  assign block_protect = bp_reg;
  assign software_protected_mode = (bp_reg != `SESP_BP_NONE);
  assign hardware_protected_mode = hw_protect;
  assign status_protect_byte = status_now;

endmodule

// ==== sim/sesp_properties.sv ====
// concurrent checks on the ports of the status and protection block
`timescale 1ns/10ps

module sesp_props #(
  parameter int unsigned WRITE_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic wp_n,
  input wire logic miso_oe,
  input wire logic array_wr_start,
  input wire logic write_in_progress_flag,
  input wire logic write_enable_latch,
  input wire logic status_write_disable,
  input wire logic [1:0] block_protect,
  input wire logic software_protected_mode,
  input wire logic hardware_protected_mode,
  input wire logic [7:0] status_protect_byte
);
  // ****************
  // busy length counter
  // ****************
  // counted here because the cycle is far longer than any repetition may be
  logic [31:0] busy_cnt_reg;
  logic [31:0] busy_cnt_next;

  always_comb begin
    busy_cnt_next = write_in_progress_flag ? busy_cnt_reg + 32'h1 : 32'h0;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_cnt_reg <= 32'h0;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_byte_layout: assert property (status_protect_byte == {status_write_disable, 3'h0, block_protect,
    write_enable_latch, write_in_progress_flag}) else $error("status byte layout wrong");
  a_busy_length: assert property ($fell(write_in_progress_flag) |-> busy_cnt_reg == WRITE_CYCLES)
    else $error("busy flag length wrong");
  a_busy_bound: assert property (busy_cnt_reg <= WRITE_CYCLES) else $error("busy flag too long");
  a_end_clears_latch: assert property ($fell(write_in_progress_flag) |-> !write_enable_latch)
    else $error("latch still set after cycle");
  a_start_needs_latch: assert property ($rose(write_in_progress_flag) |-> $past(write_enable_latch))
    else $error("cycle started without latch");
  a_protect_frozen: assert property (write_in_progress_flag && $past(write_in_progress_flag) |->
    $stable(block_protect) && $stable(status_write_disable)) else $error("protect bits moved in cycle");
  a_hw_mode_on: assert property ((status_write_disable && !wp_n) [*4] |-> hardware_protected_mode)
    else $error("hardware mode not entered");
  a_hw_mode_off: assert property (wp_n [*4] |-> !hardware_protected_mode)
    else $error("hardware mode not left");
  a_sw_mode: assert property (software_protected_mode == (block_protect != 2'h0))
    else $error("software mode wrong");
  a_start_pulse: assert property (array_wr_start |-> write_in_progress_flag &&
    !$past(write_in_progress_flag)) else $error("array start without new cycle");
  a_oe_released: assert property (cs_n [*6] |-> !miso_oe) else $error("output driven while deselected");

  c_status_done: cover property ($fell(write_in_progress_flag) && status_write_disable);
  c_array_start: cover property (array_wr_start);
  c_hw_mode: cover property (hardware_protected_mode);
  c_read_out: cover property (miso_oe);
endmodule

bind sesp_top sesp_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n),
  .wp_n(wp_n), .miso_oe(miso_oe), .array_wr_start(array_wr_start),
  .write_in_progress_flag(write_in_progress_flag), .write_enable_latch(write_enable_latch),
  .status_write_disable(status_write_disable), .block_protect(block_protect),
  .software_protected_mode(software_protected_mode), .hardware_protected_mode(hardware_protected_mode),
  .status_protect_byte(status_protect_byte));

// ==== sim/sesp_spi_master.sv ====
// serial bus master model in clock modes 0 and 3
`timescale 1ns/10ps

module sesp_spi_master (
  input wire logic ref_clk,
  input wire logic miso,
  output logic sck,
  output logic cs_n,
  output logic mosi
);
  // idle clock level: low for mode 0, high for mode 3
  logic cpol = 1'b0;

  // clock rests at its idle level outside frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // ****************
  // one frame of n bits, msb first, last 8 input bits returned
  // ****************
  task automatic frame(input logic [31:0] d, input int n, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      mosi <= d[i];
      sck <= 1'b0;
      repeat (4) @(posedge ref_clk);
      sck <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rx = {rx[6:0], miso};
    end
    // mode 0 falls after the last bit, mode 3 stays high
    sck <= cpol;
    // select rises after the last rise and before any further one
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    @(posedge ref_clk);
  endtask

  // changes the idle level only while deselected
  task automatic idle_level(input logic lvl);
    @(posedge ref_clk);
    cpol = lvl;
    sck <= lvl;
  endtask
endmodule

// ==== sim/sesp_tb.sv ====
// self-checking bench of the status and protection block
`timescale 1ns/10ps
`include "sesp_consts.svh"

module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic sck, cs_n, mosi, miso_line, miso_out, miso_oe, oe_at_end;
  logic array_wr_start, write_in_progress_flag, write_enable_latch, status_write_disable;
  logic software_protected_mode, hardware_protected_mode;
  logic [15:0] array_wr_addr;
  logic [1:0] block_protect;
  logic [7:0] status_protect_byte, rx;
  int fails = 0;
  int comparisons = 0;
  int b;
  logic [15:0] lo_tab [4] = '{16'hffff, 16'hbfff, 16'h7fff, 16'h0000};
  logic [15:0] hi_tab [4] = '{16'h0000, 16'hc000, 16'h8000, 16'hffff};
  logic [3:0] lo_ok = 4'h7;
  logic [3:0] hi_ok = 4'h1;

  always #50 ref_clk = ~ref_clk;
  // released line toggles so a stale bit cannot pass
  assign miso_line = miso_oe ? miso_out : ~sck;

  sesp_spi_master u_m (.ref_clk(ref_clk), .miso(miso_line), .sck(sck), .cs_n(cs_n), .mosi(mosi));

  sesp_top #(.WRITE_CYCLES(300)) u_dut (.ref_clk(ref_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .wp_n(wp_n), .miso_out(miso_out), .miso_oe(miso_oe), .array_wr_start(array_wr_start),
    .array_wr_addr(array_wr_addr), .write_in_progress_flag(write_in_progress_flag),
    .write_enable_latch(write_enable_latch), .status_write_disable(status_write_disable),
    .block_protect(block_protect), .software_protected_mode(software_protected_mode),
    .hardware_protected_mode(hardware_protected_mode), .status_protect_byte(status_protect_byte));

  // ****************
  // shared tasks
  // ****************
  task complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // frame, then a gap long enough for the result to land
  task cmd(input logic [31:0] d, input int n);
    u_m.frame(d, n, rx);
    oe_at_end = miso_oe;
    repeat (8) @(posedge ref_clk);
  endtask

  task wait_idle;
    int k;
    for (k = 0; k < 400 && write_in_progress_flag !== 1'b0; k++) begin
      @(posedge ref_clk);
    end
    if (k == 400) begin
      fails++;
      complete_run;
    end
  endtask

  task wsr(input logic [7:0] d);
    cmd({24'h0, `SESP_OP_ENABLE_WRITE}, 8);
    cmd({16'h0, `SESP_OP_STATUS_WRITE, d}, 16);
    wait_idle;
  endtask

  task awr(input logic [15:0] a, input logic ok);
    logic seen;
    cmd({24'h0, `SESP_OP_ENABLE_WRITE}, 8);
    u_m.frame({`SESP_OP_ARRAY_WRITE, a, 8'h5a}, 32, rx);
    seen = 1'b0;
    repeat (10) begin
      @(posedge ref_clk);
      seen = seen | array_wr_start;
    end
    chk(16'(seen), 16'(ok));
    if (ok) begin
      chk(array_wr_addr, a);
    end
    wait_idle;
    if (ok) begin
      chk(16'(write_enable_latch), 16'h0);
    end
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(16'(status_protect_byte), 16'h0000);
    cmd({16'h0, `SESP_OP_STATUS_READ, 8'h00}, 16);
    chk(16'(rx), 16'h0000);
    chk(16'(oe_at_end), 16'h1);
    cmd({16'h0, `SESP_OP_STATUS_WRITE, 8'h8c}, 16);
    chk(16'(status_protect_byte), 16'h0000);
    cmd({24'h0, `SESP_OP_ENABLE_WRITE}, 8);
    chk(16'(status_protect_byte), 16'h0002);
    cmd({8'h0, `SESP_OP_STATUS_READ, 16'h0}, 24);
    chk(16'(rx), 16'h0002);
    // same read with the clock resting high
    u_m.idle_level(1'b1);
    cmd({16'h0, `SESP_OP_STATUS_READ, 8'h00}, 16);
    chk(16'(rx), 16'h0002);
    u_m.idle_level(1'b0);
    cmd({24'h0, `SESP_OP_DISABLE_WRITE}, 8);
    chk(16'(write_enable_latch), 16'h0);
    cmd({23'h0, `SESP_OP_ENABLE_WRITE, 1'b0}, 9);
    chk(16'(write_enable_latch), 16'h0);
    cmd({16'h0, 8'hff, `SESP_OP_ENABLE_WRITE}, 16);
    chk(16'(write_enable_latch), 16'h0);
    cmd({16'h0, `SESP_OP_ARRAY_READ, `SESP_OP_ENABLE_WRITE}, 16);
    chk(16'(write_enable_latch), 16'h0);
    chk(16'(oe_at_end), 16'h0);
    cmd({24'h0, `SESP_OP_ENABLE_WRITE}, 8);
    cmd({16'h0, `SESP_OP_STATUS_WRITE, 8'hff}, 16);
    chk(16'(write_in_progress_flag), 16'h1);
    cmd({16'h0, `SESP_OP_STATUS_READ, 8'h00}, 16);
    chk(16'(rx), 16'h0003);
    chk(16'(block_protect), 16'h0);
    wait_idle;
    chk(16'(status_protect_byte), 16'h008c);
    wp_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(16'(hardware_protected_mode), 16'h1);
    wsr(8'h00);
    chk(16'(status_protect_byte & 8'hfc), 16'h008c);
    wp_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(16'(hardware_protected_mode), 16'h0);
    wsr(8'h08);
    chk(16'(status_protect_byte), 16'h0008);
    wp_n <= 1'b0;
    wsr(8'h84);
    chk(16'(status_protect_byte), 16'h0084);
    chk(16'(status_write_disable), 16'h1);
    chk(16'(hardware_protected_mode), 16'h1);
    wp_n <= 1'b1;
    // nine data bits: the select rise misses the byte boundary
    cmd({24'h0, `SESP_OP_ENABLE_WRITE}, 8);
    cmd({15'h0, `SESP_OP_STATUS_WRITE, 8'h0c, 1'b1}, 17);
    chk(16'(write_in_progress_flag), 16'h0);
    chk(16'(block_protect), 16'h1);
    for (b = 0; b < 4; b++) begin
      wsr({4'h0, 2'(b), 2'h0});
      chk(16'(block_protect), 16'(b));
      chk(16'(software_protected_mode), 16'(b != 0));
      awr(lo_tab[b], lo_ok[b]);
      awr(hi_tab[b], hi_ok[b]);
    end
    // refused writes leave the latch set; a second reset must clear it
    chk(16'(write_enable_latch), 16'h1);
    rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(16'(write_enable_latch), 16'h0);
    cmd({16'h0, `SESP_OP_STATUS_READ, 8'h00}, 16);
    chk(16'(rx), 16'h0000);
    complete_run;
  end
endmodule
